// ### src/tscr_defines.vh
`ifndef TSCR_DEFINES_VH
`define TSCR_DEFINES_VH
// ********************************************************
// Register offsets (byte addresses = offset * 4)
// ********************************************************
`define TSCR_IDX_ID_LO      7'h00
`define TSCR_IDX_ID_HI      7'h01
`define TSCR_IDX_REV        7'h02
`define TSCR_IDX_TESTLOCK   7'h03
`define TSCR_IDX_IRQ_IN_LO  7'h05
`define TSCR_IDX_IRQ_IN_HI  7'h06
`define TSCR_IDX_FREQ_TOP   7'h07
`define TSCR_IDX_IRQ_ALARM  7'h08
`define TSCR_IDX_OUTF12     7'h60
`define TSCR_IDX_OUTF34     7'h61
`define TSCR_IDX_OUTF56     7'h62
`define TSCR_IDX_OUTF7      7'h63
`define TSCR_IDX_AUXFREQ    7'h64
`define TSCR_IDX_MAINFREQ   7'h65
`define TSCR_IDX_AUXBW      7'h66
`define TSCR_IDX_MAINLBW    7'h67
`define TSCR_IDX_MAINABW    7'h69
`define TSCR_IDX_AUXDAMP    7'h6A
`define TSCR_IDX_MAINDAMP   7'h6B
`define TSCR_IDX_AUXGAIN    7'h6C
`define TSCR_IDX_MAINGAIN   7'h6D
`define TSCR_IDX_PHOFF_LO   7'h70
`define TSCR_IDX_PHOFF_HI   7'h71
`define TSCR_IDX_PBOOFF     7'h72
`define TSCR_IDX_FINELOSS   7'h73
`define TSCR_IDX_COARSELOSS 7'h74
`define TSCR_IDX_PHMON      7'h76
`define TSCR_IDX_MPH_LO     7'h77
`define TSCR_IDX_MPH_HI     7'h78
`define TSCR_IDX_ALMTMO     7'h79
`define TSCR_IDX_SYNCPULSE  7'h7A
`define TSCR_IDX_SYNCPHASE  7'h7B
`define TSCR_IDX_SYNCMON    7'h7C
`define TSCR_IDX_IRQPIN     7'h7D
`define TSCR_IDX_PROTKEY    7'h7E
`define TSCR_IDX_BUSSEL     7'h7F
// ********************************************************
// Reset values
// ********************************************************
`define TSCR_RST_TESTLOCK   8'h14
`define TSCR_RST_IRQ_IN_LO  8'hFF
`define TSCR_RST_IRQ_IN_HI  8'h3F
`define TSCR_RST_IRQ_ALARM  8'h50
`define TSCR_RST_OUTF12     8'h85
`define TSCR_RST_OUTF34     8'h86
`define TSCR_RST_OUTF56     8'h8A
`define TSCR_RST_OUTF7      8'hF6
`define TSCR_RST_AUXFREQ    8'h01
`define TSCR_RST_MAINFREQ   8'h01
`define TSCR_RST_AUXBW      8'h00
`define TSCR_RST_MAINLBW    8'h0B
`define TSCR_RST_MAINABW    8'h0F
`define TSCR_RST_AUXDAMP    8'h13
`define TSCR_RST_MAINDAMP   8'h13
`define TSCR_RST_AUXGAIN    8'hC2
`define TSCR_RST_MAINGAIN   8'hC2
`define TSCR_RST_ZERO       8'h00
`define TSCR_RST_FINELOSS   8'hA2
`define TSCR_RST_COARSELOSS 8'h85
`define TSCR_RST_PHMON      8'h06
`define TSCR_RST_ALMTMO     8'h32
`define TSCR_RST_SYNCMON    8'h2B
`define TSCR_RST_IRQPIN     8'h02
`define TSCR_RST_PROTKEY    8'h85
`define TSCR_RST_BUSSEL     8'h02
// ********************************************************
// Writable field masks (unused bits read zero)
// ********************************************************
`define TSCR_MSK_IRQ_IN_HI  8'h3F
`define TSCR_MSK_AUXFREQ    8'h77
`define TSCR_MSK_MAINFREQ   8'hF7
`define TSCR_MSK_AUXBW      8'h03
`define TSCR_MSK_BW5        8'h1F
`define TSCR_MSK_DAMP       8'h77
`define TSCR_MSK_PBOOFF     8'h3F
`define TSCR_MSK_FINELOSS   8'hE7
`define TSCR_MSK_COARSELOSS 8'hEF
`define TSCR_MSK_PHMON      8'hBF
`define TSCR_MSK_ALMTMO     8'h3F
`define TSCR_MSK_SYNCPULSE  8'h8F
`define TSCR_MSK_SYNCPHASE  8'hC3
`define TSCR_MSK_IRQPIN     8'h07
`define TSCR_MSK_TESTLOCK   8'hDC
`define TSCR_MSK_FREQ_TOP   8'h07
`define TSCR_NREG           128
`endif

// ### src/tscr_regs.v
`include "tscr_defines.vh"

module tscr_regs #(
    parameter [7:0] ID_LO = 8'h5A, // Arbitrary identity value
    parameter [7:0] ID_HI = 8'hA5, // Arbitrary identity value
    parameter [7:0] REV   = 8'h0C  // Arbitrary identity value
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [8:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    input  wire [13:0] inputValid,
    input  wire [7:0]  alarmEvent,
    input  wire [2:0]  loopFreqTop,
    input  wire [15:0] measuredPhase,
    output reg  [7:0]  auxLoopCfg_ff,
    output reg  [7:0]  mainLoopCfg_ff,
    output reg  [7:0]  fineLossCfg_ff,
    output reg  [7:0]  coarseLossCfg_ff,
    output reg  [7:0]  phaseMonCfg_ff,
    output reg  [5:0]  alarmTimeout_ff
);

    // ********************************************************
    // Input synchronisers and edge detection
    // ********************************************************
    reg  [13:0] validMeta_ff;
    reg  [13:0] validSync_ff;
    reg  [13:0] validPrev_ff;
    reg  [7:0]  alarmMeta_ff;
    reg  [7:0]  alarmSync_ff;
    reg  [7:0]  alarmPrev_ff;
    reg  [2:0]  freqMeta_ff;
    reg  [2:0]  freqSync_ff;
    reg  [15:0] phaseMeta_ff;
    reg  [15:0] phaseSync_ff;

    // A pulse shorter than a clock period may be missed
    // Reset clears the samples, so a pin already high
    // at release shows as a change three edges later
    // Alarm flags take rising edges only
    // Pins come from other logic domains; two flops each
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            validMeta_ff <= 14'h0000;
            validSync_ff <= 14'h0000;
            validPrev_ff <= 14'h0000;
            alarmMeta_ff <= 8'h00;
            alarmSync_ff <= 8'h00;
            alarmPrev_ff <= 8'h00;
            freqMeta_ff  <= 3'h0;
            freqSync_ff  <= 3'h0;
            phaseMeta_ff <= 16'h0000;
            phaseSync_ff <= 16'h0000;
        end else begin
            validMeta_ff <= inputValid;
            validSync_ff <= validMeta_ff;
            validPrev_ff <= validSync_ff;
            alarmMeta_ff <= alarmEvent;
            alarmSync_ff <= alarmMeta_ff;
            alarmPrev_ff <= alarmSync_ff;
            freqMeta_ff  <= loopFreqTop;
            freqSync_ff  <= freqMeta_ff;
            phaseMeta_ff <= measuredPhase;
            phaseSync_ff <= phaseMeta_ff;
        end
    end

    // Either direction of validity change counts as an event
    wire [13:0] validChange = validSync_ff ^ validPrev_ff;
    // Alarm sources are pulses or levels; catch rising edges
    wire [7:0]  alarmRise   = alarmSync_ff & ~alarmPrev_ff;

    // ********************************************************
    // Multi-bit status words
    // ********************************************************
    reg  [2:0]  freqLast_ff;
    reg  [2:0]  freqHeld_ff;
    reg  [15:0] phaseLast_ff;
    reg  [15:0] phaseHeld_ff;

    // Bits of a word may land in different cycles; take a
    // word only after two equal samples. Limitation: a word
    // that changes every cycle is never taken
    // One edge more delay than the validity path
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freqLast_ff  <= 3'h0;
            freqHeld_ff  <= 3'h0;
            phaseLast_ff <= 16'h0000;
            phaseHeld_ff <= 16'h0000;
        end else begin
            freqLast_ff  <= freqSync_ff;
            phaseLast_ff <= phaseSync_ff;
            if (freqSync_ff == freqLast_ff) begin
                freqHeld_ff <= freqSync_ff;
            end
            if (phaseSync_ff == phaseLast_ff) begin
                phaseHeld_ff <= phaseSync_ff;
            end
        end
    end

    // ********************************************************
    // Wishbone decode
    // ********************************************************
    // Offsets index words; byte address is offset times four
    // Only byte lane 0 holds data; other lanes are ignored
    // A request already answered is not taken again
    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [6:0]  idx     = wb_adr_i[8:2];
    wire        wrLane  = wb_we_i & wb_sel_i[0];
    wire [7:0]  wd      = wb_dat_i[7:0];

    // Index decoder for every implemented offset
    function mapped;
        input [6:0] a;
        begin
            case (a)
                `TSCR_IDX_ID_LO, `TSCR_IDX_ID_HI, `TSCR_IDX_REV, `TSCR_IDX_TESTLOCK,
                `TSCR_IDX_IRQ_IN_LO, `TSCR_IDX_IRQ_IN_HI, `TSCR_IDX_FREQ_TOP,
                `TSCR_IDX_IRQ_ALARM, `TSCR_IDX_OUTF12, `TSCR_IDX_OUTF34,
                `TSCR_IDX_OUTF56, `TSCR_IDX_OUTF7, `TSCR_IDX_AUXFREQ,
                `TSCR_IDX_MAINFREQ, `TSCR_IDX_AUXBW, `TSCR_IDX_MAINLBW,
                `TSCR_IDX_MAINABW, `TSCR_IDX_AUXDAMP, `TSCR_IDX_MAINDAMP,
                `TSCR_IDX_AUXGAIN, `TSCR_IDX_MAINGAIN, `TSCR_IDX_PHOFF_LO,
                `TSCR_IDX_PHOFF_HI, `TSCR_IDX_PBOOFF, `TSCR_IDX_FINELOSS,
                `TSCR_IDX_COARSELOSS, `TSCR_IDX_PHMON, `TSCR_IDX_MPH_LO,
                `TSCR_IDX_MPH_HI, `TSCR_IDX_ALMTMO, `TSCR_IDX_SYNCPULSE,
                `TSCR_IDX_SYNCPHASE, `TSCR_IDX_SYNCMON, `TSCR_IDX_IRQPIN,
                `TSCR_IDX_PROTKEY, `TSCR_IDX_BUSSEL: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    wire hit = req & mapped(idx);
    wire wr  = hit & wrLane;

    // Write strobe for one index
    function wsel;
        input [6:0] a;
        input [6:0] b;
        input       w;
        begin
            wsel = w & (a == b);
        end
    endfunction

    // ********************************************************
    // Interrupt flags (write-one-to-clear)
    // ********************************************************
    reg  [7:0] irqInLo_ff;
    reg  [5:0] irqInHi_ff;
    reg  [7:0] irqAlarm_ff;
    // Bits 7:6 of 0x06 have no source here and read zero

    wire [7:0] clrInLo  = wsel(idx, `TSCR_IDX_IRQ_IN_LO, wr) ? wd : 8'h00;
    wire [7:0] clrInHi  = wsel(idx, `TSCR_IDX_IRQ_IN_HI, wr) ? wd : 8'h00;
    wire [7:0] clrAlarm = wsel(idx, `TSCR_IDX_IRQ_ALARM, wr) ? wd : 8'h00;

    // Two changes between clears show as one flag
    // Clear masks come from lane 0 of a write
    // Set beats clear so an event in the clearing cycle is kept
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqInLo_ff   <= `TSCR_RST_IRQ_IN_LO;
            irqInHi_ff   <= 6'h3F;
            irqAlarm_ff  <= `TSCR_RST_IRQ_ALARM;
        end else begin
            irqInLo_ff  <= (irqInLo_ff & ~clrInLo) | validChange[7:0];
            irqInHi_ff  <= (irqInHi_ff & ~clrInHi[5:0]) | validChange[13:8];
            irqAlarm_ff <= (irqAlarm_ff & ~clrAlarm) | alarmRise;
        end
    end

    // ********************************************************
    // Read-write configuration
    // ********************************************************
    reg [7:0] cfg_ff [0:`TSCR_NREG-1];

    // Unlisted indices reset to zero
    // Reset value of a configuration index
    function [7:0] rstVal;
        input [6:0] a;
        begin
            case (a)
                `TSCR_IDX_TESTLOCK:   rstVal = `TSCR_RST_TESTLOCK;
                `TSCR_IDX_OUTF12:     rstVal = `TSCR_RST_OUTF12;
                `TSCR_IDX_OUTF34:     rstVal = `TSCR_RST_OUTF34;
                `TSCR_IDX_OUTF56:     rstVal = `TSCR_RST_OUTF56;
                `TSCR_IDX_OUTF7:      rstVal = `TSCR_RST_OUTF7;
                `TSCR_IDX_AUXFREQ:    rstVal = `TSCR_RST_AUXFREQ;
                `TSCR_IDX_MAINFREQ:   rstVal = `TSCR_RST_MAINFREQ;
                `TSCR_IDX_MAINLBW:    rstVal = `TSCR_RST_MAINLBW;
                `TSCR_IDX_MAINABW:    rstVal = `TSCR_RST_MAINABW;
                `TSCR_IDX_AUXDAMP:    rstVal = `TSCR_RST_AUXDAMP;
                `TSCR_IDX_MAINDAMP:   rstVal = `TSCR_RST_MAINDAMP;
                `TSCR_IDX_AUXGAIN:    rstVal = `TSCR_RST_AUXGAIN;
                `TSCR_IDX_MAINGAIN:   rstVal = `TSCR_RST_MAINGAIN;
                `TSCR_IDX_FINELOSS:   rstVal = `TSCR_RST_FINELOSS;
                `TSCR_IDX_COARSELOSS: rstVal = `TSCR_RST_COARSELOSS;
                `TSCR_IDX_PHMON:      rstVal = `TSCR_RST_PHMON;
                `TSCR_IDX_ALMTMO:     rstVal = `TSCR_RST_ALMTMO;
                `TSCR_IDX_SYNCMON:    rstVal = `TSCR_RST_SYNCMON;
                `TSCR_IDX_IRQPIN:     rstVal = `TSCR_RST_IRQPIN;
                `TSCR_IDX_PROTKEY:    rstVal = `TSCR_RST_PROTKEY;
                `TSCR_IDX_BUSSEL:     rstVal = `TSCR_RST_BUSSEL;
                default:              rstVal = `TSCR_RST_ZERO;
            endcase
        end
    endfunction

    // Layouts, MSB first, s = spare:
    // 0x64 s, auto-off, duty, rate, s, freq[2:0]
    // 0x65 aux phase, route, sel[1:0], s, freq[2:0]
    // 0x73 on, idle loss, test, s, s, limit[2:0]
    // 0x74 on, wide, multi, s, limit[3:0]
    // 0x76 window, s, on, build-out, limit[3:0]
    // 0x79 s, s, timeout[5:0]
    // Storable bits per index; unused bits always read zero
    function [7:0] wMask;
        input [6:0] a;
        begin
            case (a)
                `TSCR_IDX_TESTLOCK:   wMask = `TSCR_MSK_TESTLOCK;
                `TSCR_IDX_OUTF12, `TSCR_IDX_OUTF34, `TSCR_IDX_OUTF56,
                `TSCR_IDX_OUTF7, `TSCR_IDX_AUXGAIN, `TSCR_IDX_MAINGAIN,
                `TSCR_IDX_PHOFF_LO, `TSCR_IDX_PHOFF_HI, `TSCR_IDX_SYNCMON,
                `TSCR_IDX_PROTKEY, `TSCR_IDX_BUSSEL: wMask = 8'hFF;
                `TSCR_IDX_AUXFREQ:    wMask = `TSCR_MSK_AUXFREQ;
                `TSCR_IDX_MAINFREQ:   wMask = `TSCR_MSK_MAINFREQ;
                `TSCR_IDX_AUXBW:      wMask = `TSCR_MSK_AUXBW;
                `TSCR_IDX_MAINLBW, `TSCR_IDX_MAINABW: wMask = `TSCR_MSK_BW5;
                `TSCR_IDX_AUXDAMP, `TSCR_IDX_MAINDAMP: wMask = `TSCR_MSK_DAMP;
                `TSCR_IDX_PBOOFF:     wMask = `TSCR_MSK_PBOOFF;
                `TSCR_IDX_FINELOSS:   wMask = `TSCR_MSK_FINELOSS;
                `TSCR_IDX_COARSELOSS: wMask = `TSCR_MSK_COARSELOSS;
                `TSCR_IDX_PHMON:      wMask = `TSCR_MSK_PHMON;
                `TSCR_IDX_ALMTMO:     wMask = `TSCR_MSK_ALMTMO;
                `TSCR_IDX_SYNCPULSE:  wMask = `TSCR_MSK_SYNCPULSE;
                `TSCR_IDX_SYNCPHASE:  wMask = `TSCR_MSK_SYNCPHASE;
                `TSCR_IDX_IRQPIN:     wMask = `TSCR_MSK_IRQPIN;
                default:              wMask = 8'h00;
            endcase
        end
    endfunction

    // Writes to read-only indices land in unread slots
    // Whole array resets to defaults; writes store masked data
    integer i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `TSCR_NREG; i = i + 1) begin
                cfg_ff[i] <= rstVal(i[6:0]);
            end
        end else if (wr) begin
            cfg_ff[idx] <= wd & wMask(idx);
        end
    end

    // ********************************************************
    // Configuration outputs to the loop logic
    // ********************************************************
    // Registered so every output comes from a flop
    // Outputs trail a write by one edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auxLoopCfg_ff    <= `TSCR_RST_AUXFREQ;
            mainLoopCfg_ff   <= `TSCR_RST_MAINFREQ;
            fineLossCfg_ff   <= `TSCR_RST_FINELOSS;
            coarseLossCfg_ff <= `TSCR_RST_COARSELOSS;
            phaseMonCfg_ff   <= `TSCR_RST_PHMON;
            alarmTimeout_ff  <= 6'h32;
        end else begin
            auxLoopCfg_ff    <= cfg_ff[`TSCR_IDX_AUXFREQ];
            mainLoopCfg_ff   <= cfg_ff[`TSCR_IDX_MAINFREQ];
            fineLossCfg_ff   <= cfg_ff[`TSCR_IDX_FINELOSS];
            coarseLossCfg_ff <= cfg_ff[`TSCR_IDX_COARSELOSS];
            phaseMonCfg_ff   <= cfg_ff[`TSCR_IDX_PHMON];
            alarmTimeout_ff  <= cfg_ff[`TSCR_IDX_ALMTMO][5:0];
        end
    end

    // ********************************************************
    // Read mux
    // ********************************************************
    // Status words come from the filtered copies
    // Data of an unmapped index is dropped at the answer
    reg [7:0] rdByte;
    always @* begin
        case (idx)
            `TSCR_IDX_ID_LO:     rdByte = ID_LO;
            `TSCR_IDX_ID_HI:     rdByte = ID_HI;
            `TSCR_IDX_REV:       rdByte = REV;
            `TSCR_IDX_IRQ_IN_LO: rdByte = irqInLo_ff;
            `TSCR_IDX_IRQ_IN_HI: rdByte = {2'h0, irqInHi_ff};
            `TSCR_IDX_IRQ_ALARM: rdByte = irqAlarm_ff;
            `TSCR_IDX_FREQ_TOP:  rdByte = {5'h00, freqHeld_ff};
            `TSCR_IDX_MPH_LO:    rdByte = phaseHeld_ff[7:0];
            `TSCR_IDX_MPH_HI:    rdByte = phaseHeld_ff[15:8];
            default:             rdByte = cfg_ff[idx];
        endcase
    end

    // ********************************************************
    // Bus answer: one wait state, ack or err for one cycle
    // ********************************************************
    // Writes land on the request edge as ack rises; the
    // master still holds the data, so nothing is lost
    // Gating req with ack/err makes a held stb wait a gap
    // Unmapped accesses get err and zero data
    // Upper data lanes are always zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= hit;
            wb_err_o <= req & ~mapped(idx);
            wb_dat_o <= hit ? {24'h00_0000, rdByte} : 32'h0000_0000;
        end
    end

endmodule // tscr_regs

// ### bench/tscr_regs_assertions.sv
// ************************************************
// Bus answer and config output checker
// ************************************************
module tscr_regs_assertions (
    input logic        clk,
    input logic        rst_n,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [8:0]  wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        wb_err_o,
    input logic [7:0]  auxLoopCfg_ff,
    input logic [7:0]  mainLoopCfg_ff,
    input logic [7:0]  fineLossCfg_ff,
    input logic [7:0]  coarseLossCfg_ff,
    input logic [7:0]  phaseMonCfg_ff,
    input logic [5:0]  alarmTimeout_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic       req;
    logic       tmoWr;
    logic [5:0] lastTmo_ff;
    logic [5:0] nxt_lastTmo;
    // Fresh request, not the tail of an answered one
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign tmoWr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[8:2] == 7'h79;
    // Shadow of the last accepted timeout write; only six bits exist
    assign nxt_lastTmo = tmoWr ? wb_dat_i[5:0] : lastTmo_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastTmo_ff <= 6'h32;
        end else begin
            lastTmo_ff <= nxt_lastTmo;
        end
    end
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_answer_next_cycle: assert property (req |=> (wb_ack_o ^ wb_err_o))
        else $error("request not answered once in the next cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data bits set");
    a_err_unmapped: assert property (req && wb_adr_i[8:2] inside {7'h04, 7'h68, 7'h75}
        |=> wb_err_o)
        else $error("unmapped offset not refused");
    a_reset_defaults: assert property ($rose(rst_n) |-> alarmTimeout_ff == 6'h32
        && coarseLossCfg_ff == 8'h85 && fineLossCfg_ff == 8'ha2 && phaseMonCfg_ff == 8'h06
        && auxLoopCfg_ff == 8'h01 && mainLoopCfg_ff == 8'h01)
        else $error("config outputs not at defaults after reset");
    a_tmo_write_lands: assert property (tmoWr |=> ##[0:1] alarmTimeout_ff == lastTmo_ff)
        else $error("timeout write not reflected on output");
    a_tmo_read_back: assert property (req && !wb_we_i && wb_adr_i[8:2] == 7'h79
        |=> wb_dat_o[7:0] == {2'b00, alarmTimeout_ff})
        else $error("timeout readback differs from output");
endmodule // tscr_regs_assertions

bind tscr_regs tscr_regs_assertions u_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .auxLoopCfg_ff(auxLoopCfg_ff),
    .mainLoopCfg_ff(mainLoopCfg_ff), .fineLossCfg_ff(fineLossCfg_ff),
    .coarseLossCfg_ff(coarseLossCfg_ff), .phaseMonCfg_ff(phaseMonCfg_ff),
    .alarmTimeout_ff(alarmTimeout_ff)
);

// ### bench/tscr_host_model.sv
// ************************************************
// Host processor, classic bus master
// ************************************************
module tscr_host_model (
    input  wire logic        clk,
    input  wire logic        wbAck,
    input  wire logic        wbErr,
    output logic             wbCyc,
    output logic             wbStb,
    output logic             wbWe,
    output logic [8:0]       wbAdr,
    output logic [31:0]      wbDat,
    output logic [3:0]       wbSel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] expQ [$]; // Notes: {check data, expect err, byte}
    // Idle bus from time zero
    initial begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe  = 1'b0;
        wbAdr = 9'h000;
        wbDat = 32'h0000_0000;
        wbSel = 4'h0;
    end
    // One cycle; request held until the edge that sees the answer
    task automatic xfer(input logic we, input logic [6:0] idx, input logic [3:0] sel,
                        input logic [7:0] wd, input logic [9:0] note);
        int n;
        n = 0;
        expQ.push_back(note);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= sel;
        wbDat <= {24'h00_0000, wd}; // Write byte in lane 0; at 0x05/0x06/0x08 its ones clear flags
        do begin
            @(posedge clk);
            n++;
        end while (!(wbAck === 1'b1 || wbErr === 1'b1) && n < 40);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbDat <= ~wbDat; // Stale data must not look valid
        @(posedge clk);
    endtask
endmodule // tscr_host_model

// ### bench/tscr_regs_tb.sv
`include "tscr_defines.vh"
// ************************************************
// Register bank testbench
// ************************************************
module tscr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_LO_V = 8'h3c; // Arbitrary identity value
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wbCyc, wbStb, wbWe, wbAck, wbErr;
    logic [8:0]  wbAdr;
    logic [31:0] wbDatW, wbDatR;
    logic [3:0]  wbSel;
    logic [13:0] inputValid = 14'h0000;
    logic [7:0]  alarmEvent = 8'h00;
    logic [2:0]  loopFreqTop = 3'h0;
    logic [15:0] measuredPhase = 16'h0000;
    logic [7:0]  auxCfg, mainCfg, fineCfg, coarseCfg, monCfg, rnd, part;
    logic [5:0]  tmoCfg;
    logic [9:0]  note;
    logic [13:0] flag;
    logic [8:0]  co;
    logic [6:0]  idx;
    int          i, j;
    int          err_count = 0;
    int          total_checks = 0;
    int          seed = 32'h6f24_7ea2;
    // Offset, reset value, stored-bit mask of every read-write register
    logic [23:0] regTab [27] = '{24'h03_14dc, 24'h60_85ff, 24'h61_86ff, 24'h62_8aff,
        24'h63_f6ff, 24'h64_0177, 24'h65_01f7, 24'h66_0003, 24'h67_0b1f, 24'h69_0f1f,
        24'h6a_1377, 24'h6b_1377, 24'h6c_c2ff, 24'h6d_c2ff, 24'h70_00ff, 24'h71_00ff,
        24'h72_003f, 24'h73_a2e7, 24'h74_85ef, 24'h76_06bf, 24'h79_323f, 24'h7a_008f,
        24'h7b_00c3, 24'h7c_2bff, 24'h7d_0207, 24'h7e_85ff, 24'h7f_02ff};
    always #12.5 clk = ~clk;
    tscr_regs #(.ID_LO(ID_LO_V)) dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .wb_err_o(wbErr), .inputValid(inputValid),
        .alarmEvent(alarmEvent), .loopFreqTop(loopFreqTop), .measuredPhase(measuredPhase),
        .auxLoopCfg_ff(auxCfg), .mainLoopCfg_ff(mainCfg), .fineLossCfg_ff(fineCfg),
        .coarseLossCfg_ff(coarseCfg), .phaseMonCfg_ff(monCfg), .alarmTimeout_ff(tmoCfg));
    tscr_host_model host (.clk(clk), .wbAck(wbAck), .wbErr(wbErr), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDat(wbDatW), .wbSel(wbSel));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 4'h1, 8'h00, {2'b10, e});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, 4'h1, d, 10'h000);
    endtask
    task automatic close_out();
        check(host.expQ.size(), 32'h0000_0000);
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Config output that mirrors an offset, if any
    function automatic logic [8:0] cfgOut(input logic [6:0] a);
        case (a)
            7'h64: cfgOut = {1'b1, auxCfg};
            7'h65: cfgOut = {1'b1, mainCfg};
            7'h73: cfgOut = {1'b1, fineCfg};
            7'h74: cfgOut = {1'b1, coarseCfg};
            7'h76: cfgOut = {1'b1, monCfg};
            7'h79: cfgOut = {3'b100, tmoCfg};
            default: cfgOut = 9'h000;
        endcase
    endfunction
    // Oldest note matched against each answer; data only where a read
    always @(posedge clk) begin
        if (wbAck === 1'b1 || wbErr === 1'b1) begin
            note = host.expQ.pop_front();
            check({22'h0, note[9], wbErr, note[9] ? wbDatR[7:0] : 8'h00}, {22'h0, note});
        end
    end
    // Cut a hang short; run is about 1400 cycles of the 16000 allowed
    initial begin
        #400_000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 27; i++) begin
            rd(regTab[i][22:16], regTab[i][15:8]);
        end
        for (i = 0; i < 27; i++) begin
            rnd = $random(seed);
            wr(regTab[i][22:16], rnd);
            rd(regTab[i][22:16], rnd & regTab[i][7:0]);
            co = cfgOut(regTab[i][22:16]);
            if (co[8] === 1'b1) check({24'h0, co[7:0]}, {24'h0, rnd & regTab[i][7:0]});
        end
        $display("test config done");
        rd(7'h05, 8'hff);
        rd(7'h06, 8'h3f);
        rd(7'h08, 8'h50);
        wr(7'h05, 8'h00);
        rd(7'h05, 8'hff);
        wr(7'h05, 8'hff);
        wr(7'h06, 8'hff);
        wr(7'h08, 8'hff);
        rd(7'h05, 8'h00);
        rd(7'h06, 8'h00);
        rd(7'h08, 8'h00);
        // Every input goes valid, later invalid; sync needs three edges
        for (i = 0; i < 28; i++) begin
            inputValid[i % 14] <= ~inputValid[i % 14];
            repeat (4) @(posedge clk);
            flag = 14'h0001 << (i % 14);
            for (j = 0; j < 2; j++) begin
                idx = j ? 7'h06 : 7'h05;
                part = j ? {2'b00, flag[13:8]} : flag[7:0];
                rd(idx, part);
                wr(idx, ~part);
                rd(idx, part);
                wr(idx, part);
                rd(idx, 8'h00);
            end
        end
        $display("test validity flags done");
        for (i = 0; i < 8; i++) begin
            alarmEvent[i] <= 1'b1;
            repeat (4) @(posedge clk);
            alarmEvent[i] <= 1'b0;
            rd(7'h08, 8'h01 << i);
            wr(7'h08, 8'h01 << i);
            rd(7'h08, 8'h00);
        end
        $display("test alarm flags done");
        rnd = $random(seed);
        loopFreqTop <= rnd[2:0];
        measuredPhase <= {rnd, ~rnd};
        repeat (4) @(posedge clk);
        wr(7'h00, 8'h00);
        rd(7'h00, ID_LO_V);
        rd(7'h07, {5'h00, rnd[2:0]});
        wr(7'h77, rnd);
        rd(7'h77, ~rnd);
        rd(7'h78, rnd);
        host.xfer(1'b0, 7'h04, 4'h1, 8'h00, 10'h100);
        host.xfer(1'b1, 7'h68, 4'h1, 8'hff, 10'h100);
        host.xfer(1'b0, 7'h75, 4'h1, 8'h00, 10'h100);
        wr(7'h79, 8'hff);
        host.xfer(1'b1, 7'h79, 4'h0, 8'h15, 10'h000);
        rd(7'h79, 8'h3f);
        $display("test read-only and refusals done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(7'h79, 8'h32);
        rd(7'h06, 8'h3f);
        $display("test second reset done");
        close_out();
    end
endmodule // tscr_regs_tb
